// [hw/cfx_defs.svh]
// constants of the configuration transaction forwarder
`ifndef CFX_DEFS_SVH
`define CFX_DEFS_SVH

// bus commands on cbe during the address phase
`define CFX_CMD_CFG_RD   4'hA
`define CFX_CMD_CFG_WR   4'hB
`define CFX_CMD_SPECIAL  4'h1

// address bits 1:0 of the two configuration formats
`define CFX_TYPE0        2'h0
`define CFX_TYPE1        2'h1

// field positions inside the configuration address
`define CFX_BUS_HI       23
`define CFX_BUS_LO       16
`define CFX_DEV_HI       15
`define CFX_DEV_LO       11
`define CFX_FN_HI        10
`define CFX_FN_LO        8
`define CFX_REG_HI       7
`define CFX_REG_LO       2
`define CFX_IDSEL_LO     16

// special field values
`define CFX_DEV_ALL      5'h1F
`define CFX_FN_ALL       3'h7
`define CFX_REG_ZERO     6'h00
`define CFX_IDSEL_DEVS   5'h10

// reset and idle values, and the read word of a missing target
`define CFX_DESELECT     1'b1
`define CFX_ZERO_WORD    32'h0000_0000
`define CFX_ABORT_DATA   32'hFFFF_FFFF

`endif

// [hw/cfx_pkg.sv]
// types shared by the configuration transaction forwarder
package cfx_pkg;

    typedef enum logic [2:0] {
        CFX_CLAIM_NONE = 3'b000,
        CFX_CLAIM_OWN  = 3'b001,
        CFX_CLAIM_CONV = 3'b010,
        CFX_CLAIM_DOWN = 3'b011,
        CFX_CLAIM_UP   = 3'b100
    } cfx_claim_e;

    typedef enum logic [1:0] {
        CFX_TS_IDLE    = 2'b00,
        CFX_TS_CLAIMED = 2'b01,
        CFX_TS_XFER    = 2'b10,
        CFX_TS_STOP    = 2'b11
    } cfx_tstate_e;

    typedef struct packed {
        logic        frameN;
        logic        irdyN;
        logic [3:0]  cbe;
        logic [31:0] ad;
    } cfx_bus_in_t;

    typedef struct packed {
        logic        trdyN;
        logic        stopN;
        logic        adOe;
        logic [31:0] ad;
    } cfx_tgt_out_t;

    typedef struct packed {
        logic        valid;
        logic        toSecondary;
        logic [3:0]  cmd;
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0]  be;
    } cfx_fwd_req_t;

    typedef struct packed {
        logic        strobe;
        logic [5:0]  regNum;
        logic [31:0] data;
        logic [3:0]  be;
    } cfx_own_wr_t;

    typedef struct packed {
        cfx_tstate_e  state;
        cfx_claim_e   kind;
        logic         prevFrameN;
        logic         devselN;
        logic [3:0]   cmd;
        logic [3:0]   fwdCmd;
        logic [31:0]  origAddr;
        logic [31:0]  fwdAddr;
        cfx_tgt_out_t out;
    } cfx_tgt_st_t;

    typedef struct packed {
        logic        busy;
        logic        done;
        logic        side;
        logic [3:0]  cmd;
        logic [31:0] origAddr;
        logic [31:0] rdData;
    } cfx_dly_st_t;

    typedef struct packed {
        cfx_tgt_st_t [1:0] tgt;
        cfx_dly_st_t       dly;
        cfx_fwd_req_t      fwd;
        cfx_own_wr_t       own;
    } cfx_state_t;

endpackage

// [hw/cfx_cfg_decode.sv]
// address-phase claim decode for one side of the bridge
`timescale 1ns/1ps
`include "cfx_defs.svh"
module cfx_cfg_decode #(
    parameter bit IS_PRIMARY = 1'b1
) (
    input  wire logic [31:0]         ad,         // address phase ad
    input  wire logic [3:0]          cbe,        // address phase command
    input  wire logic                idSelect,   // own select, primary only
    input  wire logic [7:0]          secBusNum,  // secondary bus number
    input  wire logic [7:0]          subBusNum,  // subordinate bus number
    output cfx_pkg::cfx_claim_e      claim       // what this access is
);
    import cfx_pkg::*;

    logic       isCfg;
    logic       isWr;
    logic [7:0] busNum;
    logic       inRange;
    logic       isSec;

    assign isCfg  = (cbe == `CFX_CMD_CFG_RD) || (cbe == `CFX_CMD_CFG_WR);
    assign isWr   = (cbe == `CFX_CMD_CFG_WR);
    assign busNum = ad[`CFX_BUS_HI:`CFX_BUS_LO];
    assign isSec  = (busNum == secBusNum);
    assign inRange = (busNum > secBusNum) && (busNum <= subBusNum);

    always_comb begin
        claim = CFX_CLAIM_NONE;
        if (IS_PRIMARY) begin
            if (isCfg && ad[1:0] == `CFX_TYPE0 && idSelect) begin
                claim = CFX_CLAIM_OWN;
            end else if (isCfg && ad[1:0] == `CFX_TYPE1 && isSec) begin
                claim = CFX_CLAIM_CONV;
            end else if (isCfg && ad[1:0] == `CFX_TYPE1 && inRange) begin
                claim = CFX_CLAIM_DOWN;
            end
        end else if (isWr && ad[1:0] == `CFX_TYPE1
                     && ad[`CFX_DEV_HI:`CFX_DEV_LO] == `CFX_DEV_ALL
                     && ad[`CFX_FN_HI:`CFX_FN_LO] == `CFX_FN_ALL
                     && !isSec && !inRange) begin
            claim = CFX_CLAIM_UP;
        end
    end
endmodule

// [hw/cfx_idsel_map.sv]
// type 1 to type 0 address translation with one-hot device select
`timescale 1ns/1ps
`include "cfx_defs.svh"
module cfx_idsel_map (
    input  wire logic [31:0] type1Addr,   // primary type 1 address
    output logic      [31:0] type0Addr,   // translated secondary address
    output logic             specialCyc   // device all-ones, register zero
);
    logic [4:0]  devNum;
    logic [15:0] oneHot;

    assign devNum = type1Addr[`CFX_DEV_HI:`CFX_DEV_LO];

    always_comb begin
        oneHot = 16'h0000;
        if (devNum < `CFX_IDSEL_DEVS) begin
            oneHot[devNum[3:0]] = 1'b1;
        end
    end

    // device all-ones with register zero is special
    assign specialCyc = (devNum == `CFX_DEV_ALL)
        && (type1Addr[`CFX_REG_HI:`CFX_REG_LO] == `CFX_REG_ZERO);

    // clear 15:11 and 1:0, keep function and register
    assign type0Addr = {oneHot, 5'h00,
                        type1Addr[`CFX_FN_HI:`CFX_REG_LO], 2'h0};
endmodule

// [hw/cfx_forwarder.sv]
// configuration transaction claim, conversion and forwarding
`timescale 1ns/1ps
`include "cfx_defs.svh"
module cfx_forwarder (
    input  wire logic                  core_clk,              // pci clock
    input  wire logic                  reset_n,               // async reset
    input  wire cfx_pkg::cfx_bus_in_t  priBus,                // primary in
    input  wire logic                  primary_id_select_in,  // own select
    output cfx_pkg::cfx_tgt_out_t      priOut,                // primary out
    output logic                       primary_device_select_n, // claim
    input  wire cfx_pkg::cfx_bus_in_t  secBus,                // secondary in
    output cfx_pkg::cfx_tgt_out_t      secOut,                // secondary out
    output logic                       secDeviceSelectN,      // claim
    input  wire logic [7:0]            secBusNum,             // sec bus
    input  wire logic [7:0]            subBusNum,             // sub bus
    output cfx_pkg::cfx_own_wr_t       ownAccess,             // own regs
    input  wire logic [31:0]           ownRdData,             // own word
    output cfx_pkg::cfx_fwd_req_t      fwdReq,                // to master
    input  wire logic                  fwdDone,               // finished
    input  wire logic [31:0]           fwdRdData,             // read word
    input  wire logic                  fwdMasterAbort         // no target
);
    import cfx_pkg::*;

    cfx_state_t  st;
    cfx_state_t  next_st;
    cfx_claim_e  priClaim;
    cfx_claim_e  secClaim;
    logic [31:0] convAddr;
    logic        convSpecial;

    cfx_cfg_decode #(
        .IS_PRIMARY (1'b1)
    ) u_pri_decode (
        .ad        (priBus.ad),
        .cbe       (priBus.cbe),
        .idSelect  (primary_id_select_in),
        .secBusNum (secBusNum),
        .subBusNum (subBusNum),
        .claim     (priClaim)
    );

    cfx_cfg_decode #(
        .IS_PRIMARY (1'b0)
    ) u_sec_decode (
        .ad        (secBus.ad),
        .cbe       (secBus.cbe),
        .idSelect  (1'b0),
        .secBusNum (secBusNum),
        .subBusNum (subBusNum),
        .claim     (secClaim)
    );

    cfx_idsel_map u_idsel_map (
        .type1Addr  (priBus.ad),
        .type0Addr  (convAddr),
        .specialCyc (convSpecial)
    );

    function automatic cfx_state_t rstState();
        cfx_state_t r;
        r = '0;
        for (int s = 0; s < 2; s++) begin
            r.tgt[s].state      = CFX_TS_IDLE;
            r.tgt[s].kind       = CFX_CLAIM_NONE;
            r.tgt[s].prevFrameN = `CFX_DESELECT;
            r.tgt[s].devselN    = `CFX_DESELECT;
            r.tgt[s].out.trdyN  = `CFX_DESELECT;
            r.tgt[s].out.stopN  = `CFX_DESELECT;
        end
        return r;
    endfunction

    always_comb begin
        cfx_tgt_st_t t;
        cfx_bus_in_t b;
        cfx_claim_e  c;
        logic        addrPhase;
        logic        isRead;
        logic        match;
        t = '0;
        b = '0;
        c = CFX_CLAIM_NONE;
        addrPhase = 1'b0;
        isRead = 1'b0;
        match = 1'b0;
        next_st = st;
        next_st.own.strobe = 1'b0;

        // the far master finished; a missing target reads as all ones
        if (st.fwd.valid && fwdDone) begin
            next_st.fwd.valid  = 1'b0;
            next_st.dly.done   = 1'b1;
            next_st.dly.rdData = fwdMasterAbort ? `CFX_ABORT_DATA
                                                : fwdRdData;
        end

        for (int s = 0; s < 2; s++) begin
            t = st.tgt[s];
            b = (s == 0) ? priBus : secBus;
            c = (s == 0) ? priClaim : secClaim;
            addrPhase = t.prevFrameN && !b.frameN;
            isRead = (t.cmd == `CFX_CMD_CFG_RD);
            t.prevFrameN = b.frameN;
            unique case (t.state)
                CFX_TS_IDLE: begin
                    if (addrPhase && c != CFX_CLAIM_NONE) begin
                        t.state    = CFX_TS_CLAIMED;
                        t.kind     = c;
                        t.devselN  = 1'b0;
                        t.cmd      = b.cbe;
                        t.fwdCmd   = b.cbe;
                        t.origAddr = b.ad;
                        t.fwdAddr  = b.ad;
                        // translation only on the primary side
                        if (s == 0 && c == CFX_CLAIM_CONV) begin
                            t.fwdAddr = convAddr;
                            if (convSpecial
                                && b.cbe == `CFX_CMD_CFG_WR) begin
                                t.fwdCmd  = `CFX_CMD_SPECIAL;
                                t.fwdAddr = b.ad;
                            end
                        end
                        if (c == CFX_CLAIM_OWN) begin
                            next_st.own.regNum =
                                b.ad[`CFX_REG_HI:`CFX_REG_LO];
                        end
                    end
                end
                CFX_TS_CLAIMED: begin
                    if (!b.irdyN) begin
                        if (t.kind == CFX_CLAIM_OWN) begin
                            t.state     = CFX_TS_XFER;
                            t.out.trdyN = 1'b0;
                            t.out.stopN = b.frameN;
                            t.out.adOe  = isRead;
                            t.out.ad    = ownRdData;
                            if (!isRead) begin
                                next_st.own.strobe = 1'b1;
                                next_st.own.data   = b.ad;
                                next_st.own.be     = b.cbe;
                            end
                        end else begin
                            match = st.dly.busy && st.dly.side == s[0]
                                && st.dly.cmd == t.cmd
                                && st.dly.origAddr == t.origAddr;
                            if (match && st.dly.done) begin
                                t.state     = CFX_TS_XFER;
                                t.out.trdyN = 1'b0;
                                t.out.stopN = b.frameN;
                                t.out.adOe  = isRead;
                                t.out.ad    = st.dly.rdData;
                                next_st.dly.busy = 1'b0;
                                next_st.dly.done = 1'b0;
                            end else begin
                                t.state     = CFX_TS_STOP;
                                t.out.stopN = 1'b0;
                                if (!match && !next_st.dly.busy) begin
                                    next_st.dly.busy     = 1'b1;
                                    next_st.dly.done     = 1'b0;
                                    next_st.dly.side     = s[0];
                                    next_st.dly.cmd      = t.cmd;
                                    next_st.dly.origAddr = t.origAddr;
                                    next_st.fwd.valid    = 1'b1;
                                    next_st.fwd.toSecondary = (s == 0);
                                    next_st.fwd.cmd      = t.fwdCmd;
                                    next_st.fwd.addr     = t.fwdAddr;
                                    next_st.fwd.data     = b.ad;
                                    next_st.fwd.be       = b.cbe;
                                end
                            end
                        end
                    end
                end
                CFX_TS_XFER: begin
                    // data moved on this edge; release the bus
                    t.out.trdyN = 1'b1;
                    t.out.adOe  = 1'b0;
                    if (b.frameN) begin
                        t.state     = CFX_TS_IDLE;
                        t.devselN   = 1'b1;
                        t.out.stopN = 1'b1;
                    end else begin
                        t.state = CFX_TS_STOP;
                    end
                end
                CFX_TS_STOP: begin
                    // hold stop until the initiator drops frame
                    if (b.frameN) begin
                        t.state     = CFX_TS_IDLE;
                        t.devselN   = 1'b1;
                        t.out.stopN = 1'b1;
                    end
                end
            endcase
            next_st.tgt[s] = t;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= rstState();
        end else begin
            st <= next_st;
        end
    end

    assign priOut                  = st.tgt[0].out;
    assign primary_device_select_n = st.tgt[0].devselN;
    assign secOut                  = st.tgt[1].out;
    assign secDeviceSelectN        = st.tgt[1].devselN;
    assign ownAccess               = st.own;
    assign fwdReq                  = st.fwd;
endmodule

// [tb/cfx_forwarder_checker.sv]
// port assertions for the configuration forwarder
`timescale 1ns/1ps
`include "cfx_defs.svh"
module cfx_forwarder_checker (
    input wire logic                  core_clk,                // clock
    input wire logic                  reset_n,                 // reset
    input wire cfx_pkg::cfx_bus_in_t  priBus,                  // primary
    input wire logic                  primary_id_select_in,    // idsel
    input wire cfx_pkg::cfx_tgt_out_t priOut,                  // primary
    input wire logic                  primary_device_select_n, // claim
    input wire cfx_pkg::cfx_bus_in_t  secBus,                  // secondary
    input wire cfx_pkg::cfx_tgt_out_t secOut,                  // secondary
    input wire logic                  secDeviceSelectN,        // claim
    input wire logic [7:0]            secBusNum,               // sec bus
    input wire logic [7:0]            subBusNum,               // sub bus
    input wire cfx_pkg::cfx_fwd_req_t fwdReq,                  // request
    input wire logic                  fwdDone,                 // finished
    input wire logic                  fwdMasterAbort           // no target
);
    import cfx_pkg::*;
    logic        pF, sF, pA, sA, pCfg;
    logic [31:0] pAd;
    logic [15:0] expSel;
    // only a fresh frame with the target idle counts as an address phase
    assign pA = !priBus.frameN && pF && primary_device_select_n;
    assign sA = !secBus.frameN && sF && secDeviceSelectN;
    assign pCfg = priBus.cbe == `CFX_CMD_CFG_RD ||
                  priBus.cbe == `CFX_CMD_CFG_WR;
    assign expSel = pAd[15] ? 16'h0000 : 16'h0001 << pAd[14:11];
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pF  <= 1'b1;
            sF  <= 1'b1;
            pAd <= 32'h0000_0000;
        end else begin
            pF <= priBus.frameN;
            sF <= secBus.frameN;
            if (pA) begin
                pAd <= priBus.ad;
            end
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    property p_own_claim;
        pA && pCfg && priBus.ad[1:0] == `CFX_TYPE0 && primary_id_select_in
            |=> !primary_device_select_n;
    endproperty
    a_own_claim: assert property (p_own_claim)
        else $error("own config access not claimed");
    property p_no_claim;
        pA && (!pCfg ||
            priBus.ad[1:0] == `CFX_TYPE0 && !primary_id_select_in)
            |=> primary_device_select_n[*3];
    endproperty
    a_no_claim: assert property (p_no_claim)
        else $error("primary access claimed without cause");
    property p_sec_t0;
        sA && secBus.ad[1:0] == `CFX_TYPE0 |=> secDeviceSelectN[*3];
    endproperty
    a_sec_t0: assert property (p_sec_t0)
        else $error("secondary type 0 access claimed");
    property p_t1_claim;
        pA && pCfg && priBus.ad[1:0] == `CFX_TYPE1 &&
            priBus.ad[23:16] >= secBusNum && priBus.ad[23:16] <= subBusNum
            |=> !primary_device_select_n;
    endproperty
    a_t1_claim: assert property (p_t1_claim)
        else $error("type 1 access for lower bus not claimed");
    property p_up;
        sA && secBus.cbe == `CFX_CMD_CFG_WR &&
            secBus.ad[1:0] == `CFX_TYPE1 && secBus.ad[15:8] == 8'hFF &&
            (secBus.ad[23:16] < secBusNum || secBus.ad[23:16] > subBusNum)
            |=> !secDeviceSelectN;
    endproperty
    a_up: assert property (p_up)
        else $error("upstream special write not claimed");
    property p_conv;
        $rose(fwdReq.valid) && fwdReq.addr[1:0] == `CFX_TYPE0
            |-> fwdReq.toSecondary &&
            fwdReq.addr == {expSel, 5'h00, pAd[10:2], 2'h0};
    endproperty
    a_conv: assert property (p_conv)
        else $error("converted address wrong");
    property p_disc;
        !priOut.trdyN && !$past(priBus.frameN) |-> !priOut.stopN;
    endproperty
    a_disc: assert property (p_disc)
        else $error("no disconnect with data on burst");
    property p_retry;
        $rose(fwdReq.valid) |-> (!priOut.stopN && priOut.trdyN) ||
            (!secOut.stopN && secOut.trdyN);
    endproperty
    a_retry: assert property (p_retry)
        else $error("forwarded request not answered by retry");
    property p_own_fast;
        pA && pCfg && priBus.ad[1:0] == `CFX_TYPE0 && primary_id_select_in
            |=> (!$rose(fwdReq.valid))[*4];
    endproperty
    a_own_fast: assert property (p_own_fast)
        else $error("own access went through forwarding");
    c_own: cover property (pA && primary_id_select_in);
    c_conv: cover property ($rose(fwdReq.valid) && fwdReq.toSecondary);
    c_up: cover property ($rose(fwdReq.valid) && !fwdReq.toSecondary);
    c_abort: cover property (fwdDone && fwdMasterAbort);
endmodule

bind cfx_forwarder cfx_forwarder_checker u_chk (
    .core_clk, .reset_n, .priBus, .primary_id_select_in, .priOut,
    .primary_device_select_n, .secBus, .secOut, .secDeviceSelectN,
    .secBusNum, .subBusNum, .fwdReq, .fwdDone, .fwdMasterAbort
);

// [tb/cfx_far_master.sv]
// far-side master that carries out forwarded requests
`timescale 1ns/1ps
`include "cfx_defs.svh"
module cfx_far_master (
    input  wire logic                  core_clk,       // pci clock
    input  wire logic                  reset_n,        // async reset
    input  wire logic                  slow,           // long latency
    input  wire cfx_pkg::cfx_fwd_req_t fwdReq,         // request
    output logic                       fwdDone,        // finished
    output logic [31:0]                fwdRdData,      // read word
    output logic                       fwdMasterAbort  // nobody answered
);
    import cfx_pkg::*;
    logic [3:0] cnt;
    logic       noTarget;
    // no select line or special cycle: nobody claims it
    assign noTarget = fwdReq.cmd == `CFX_CMD_SPECIAL ||
        (fwdReq.addr[1:0] == `CFX_TYPE0 && fwdReq.addr[31:16] == 16'h0000);
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt            <= 4'h0;
            fwdDone        <= 1'b0;
            fwdMasterAbort <= 1'b0;
            fwdRdData      <= 32'h0000_0000;
        end else begin
            fwdDone        <= 1'b0;
            fwdMasterAbort <= 1'b0;
            // released lines never keep the last word
            fwdRdData      <= ~fwdRdData;
            if (fwdReq.valid && !fwdDone) begin
                cnt <= cnt + 4'h1;
                if (cnt == (slow ? 4'h9 : 4'h0)) begin
                    cnt            <= 4'h0;
                    fwdDone        <= 1'b1;
                    fwdMasterAbort <= noTarget;
                    fwdRdData      <= noTarget ? ~fwdRdData :
                                      fwdReq.addr ^ 32'h5A5A_5A5A;
                end
            end
        end
    end
endmodule

// [tb/cfx_forwarder_tb_top.sv]
// self-checking bench for the configuration forwarder
`timescale 1ns/1ps
`include "cfx_defs.svh"
module cfx_forwarder_tb_top;
    import cfx_pkg::*;
    logic         core_clk = 1'b0;
    logic         reset_n  = 1'b0;
    logic         idSel    = 1'b0;
    logic         slow     = 1'b0;
    logic [7:0]   secNum   = 8'h05;
    logic [7:0]   subNum   = 8'h09;
    logic [31:0]  ownRd    = 32'hA5A5_5A5A;
    logic         pDsel, sDsel, fDone, fAbort;
    logic [31:0]  fRd;
    cfx_bus_in_t  bi [2];
    cfx_tgt_out_t pOut, sOut;
    cfx_own_wr_t  own, ownSeen;
    cfx_fwd_req_t fwd, fwdSeen;
    logic         oeSeen;
    int           n_mismatch   = 0;
    int           total_checks = 0;
    always #10 core_clk = ~core_clk;
    cfx_forwarder dut (
        .core_clk(core_clk), .reset_n(reset_n), .priBus(bi[0]),
        .primary_id_select_in(idSel), .priOut(pOut),
        .primary_device_select_n(pDsel), .secBus(bi[1]), .secOut(sOut),
        .secDeviceSelectN(sDsel), .secBusNum(secNum), .subBusNum(subNum),
        .ownAccess(own), .ownRdData(ownRd), .fwdReq(fwd), .fwdDone(fDone),
        .fwdRdData(fRd), .fwdMasterAbort(fAbort)
    );
    cfx_far_master far (
        .core_clk(core_clk), .reset_n(reset_n), .slow(slow), .fwdReq(fwd),
        .fwdDone(fDone), .fwdRdData(fRd), .fwdMasterAbort(fAbort)
    );
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one access on side s; rsp bit 1 is stop, bit 0 is trdy
    task automatic xfer(input bit s, input logic [3:0] cmd,
            input logic [31:0] adr, input logic [31:0] dat, input bit bst,
            output logic [1:0] rsp, output logic [31:0] rd, output bit ds);
        cfx_tgt_out_t o;
        rsp = 2'h0;
        ds  = 1'b0;
        @(negedge core_clk);
        bi[s] = '{1'b0, 1'b1, cmd, adr};
        @(negedge core_clk);
        bi[s] = '{1'b0, 1'b1, 4'hE, dat};
        @(negedge core_clk);
        bi[s] = '{!bst, 1'b0, 4'hE, dat};
        for (int i = 0; i < 8 && rsp == 2'h0; i++) begin
            @(negedge core_clk);
            o = s ? sOut : pOut;
            ds |= !(s ? sDsel : pDsel);
            rsp = {!o.stopN, !o.trdyN};
            rd = o.ad;
            oeSeen = o.adOe;
            ownSeen = own;
            fwdSeen = fwd;
        end
        // released lines carry the inverse, not the last word
        bi[s] = '{1'b1, 1'b1, 4'h0, ~dat};
        repeat (3) @(negedge core_clk);
    endtask
    task automatic nc(input bit s, input logic [3:0] cmd,
            input logic [31:0] adr);
        logic [1:0]  rsp;
        logic [31:0] rd;
        bit          ds;
        xfer(s, cmd, adr, 32'h0000_0000, 1'b0, rsp, rd, ds);
        chk({31'h0, ds}, 32'h0000_0000);
    endtask
    task automatic fwd_run(input bit s, input logic [3:0] cmd,
            input logic [31:0] adr, input logic [31:0] eAdr,
            input logic [3:0] eCmd, input logic [31:0] eRd);
        logic [1:0]  rsp;
        logic [31:0] rd;
        bit          ds;
        int          n;
        xfer(s, cmd, adr, 32'h1234_5678, 1'b1, rsp, rd, ds);
        chk(fwdSeen.addr, eAdr);
        chk(fwdSeen.data, 32'h1234_5678);
        chk({19'h0, fwdSeen.be, rsp, ds, fwdSeen.valid,
            fwdSeen.toSecondary, fwdSeen.cmd},
            {19'h0, 4'hE, 2'h2, 2'h3, !s, eCmd});
        for (n = 0; n < 20 && rsp != 2'h3; n++) begin
            xfer(s, cmd, adr, 32'h1234_5678, 1'b1, rsp, rd, ds);
        end
        if (n == 20) begin
            n_mismatch++;
            results();
        end
        chk({31'h0, oeSeen}, {31'h0, cmd == `CFX_CMD_CFG_RD});
        if (cmd == `CFX_CMD_CFG_RD) begin
            chk(rd, eRd);
        end
    endtask
    task automatic t_own;
        logic [1:0]  rsp;
        logic [31:0] rd;
        bit          ds;
        idSel = 1'b1;
        xfer(0, `CFX_CMD_CFG_RD, 32'h0000_0510, 32'h0, 1, rsp, rd, ds);
        chk({29'h0, oeSeen, rsp}, 32'h0000_0007);
        chk(rd, ownRd);
        xfer(0, `CFX_CMD_CFG_WR, 32'h0000_0214, 32'hC0DE_0001, 0, rsp, rd, ds);
        chk({29'h0, oeSeen, rsp}, 32'h0000_0001);
        chk(ownSeen.data, 32'hC0DE_0001);
        chk({21'h0, ownSeen.be, ownSeen.strobe, ownSeen.regNum},
            32'h0000_0745);
        nc(0, 4'h6, 32'h0000_0010);
        idSel = 1'b0;
        nc(0, `CFX_CMD_CFG_RD, 32'h0000_0010);
    endtask
    task automatic t_conv;
        logic [4:0]  dev [6];
        logic [31:0] a, e;
        dev = '{5'h00, 5'h07, 5'h0F, 5'h10, 5'h1E, 5'h1F};
        foreach (dev[i]) begin
            slow = i[0];
            a = {8'h00, secNum, dev[i], 3'h3, 6'h21, 2'h1};
            e = {dev[i][4] ? 16'h0000 : 16'h0001 << dev[i][3:0],
                5'h00, 3'h3, 6'h21, 2'h0};
            fwd_run(0, `CFX_CMD_CFG_RD, a, e, `CFX_CMD_CFG_RD,
                dev[i][4] ? 32'hFFFF_FFFF : e ^ 32'h5A5A_5A5A);
        end
        a = {8'h00, secNum, 5'h1F, 3'h7, 6'h00, 2'h1};
        fwd_run(0, `CFX_CMD_CFG_WR, a, a, `CFX_CMD_SPECIAL, a);
    endtask
    task automatic t_fwd;
        logic [31:0] a;
        a = {8'h00, subNum, 5'h03, 3'h0, 6'h02, 2'h1};
        fwd_run(0, `CFX_CMD_CFG_WR, a, a, `CFX_CMD_CFG_WR, a);
        a[23:16] = 8'h06;
        fwd_run(0, `CFX_CMD_CFG_RD, a, a, `CFX_CMD_CFG_RD,
            a ^ 32'h5A5A_5A5A);
        a[23:16] = 8'h0A;
        nc(0, `CFX_CMD_CFG_RD, a);
        a = {8'h00, 8'h02, 5'h1F, 3'h7, 6'h05, 2'h1};
        fwd_run(1, `CFX_CMD_CFG_WR, a, a, `CFX_CMD_CFG_WR, a);
        nc(1, `CFX_CMD_CFG_RD, a);
        a[23:16] = secNum;
        nc(1, `CFX_CMD_CFG_WR, a);
        nc(1, `CFX_CMD_CFG_RD, 32'h0001_0004);
    endtask
    initial begin
        bi[0] = '{1'b1, 1'b1, 4'h0, 32'h0000_0000};
        bi[1] = '{1'b1, 1'b1, 4'h0, 32'h0000_0000};
        repeat (6) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (2) @(negedge core_clk);
        t_own();
        t_conv();
        t_fwd();
        results();
    end
endmodule
